// ==== hdl/cped_top.sv ====
// CAN error detection: bit, CRC, ack, form and stuff checks
//
// What this block does
// - Compare driven and sampled bits; flag if enabled
// - Transmitter sends computed CRC in the frame
// - Receiver flags CRC mismatch against received CRC
// - Correct receiver drives dominant acknowledge
// - Unacknowledged transmitted frame sets acknowledge error
// - Broken fixed-format field bit sets form error
// - Insert complement after five equal stuffed bits
// - Sixth equal bit in stuffed segment: stuff error
// - CRC errors reach CPU via error interrupt
// - Receive input drivable from embedded pattern source
// - Digital and analog loopback paths offered
`timescale 1ns/1ps
`default_nettype none

module cped_top
  import cped_pkg::*;
(
  input  wire logic           CLK,
  input  wire logic           RST_N,
  input  wire logic           CE,
  input  wire logic           BIT_TICK,
  input  wire logic           TX_ACTIVE,
  input  wire cped_field_type FIELD,
  input  wire logic           TX_DATA,
  input  wire cped_loop_type  LOOP_SEL,
  input  wire logic           BIT_CHK_EN,
  input  wire logic           CAN_RX,
  input  wire logic           PAT_RX,
  input  wire cped_err_type   ERR_EN,
  input  wire cped_err_type   ERR_CLR,
  output logic                CAN_TX,
  output logic                CAN_TX_OE_N,
  output logic                TX_TAKE,
  output logic                RX_VALID,
  output logic                RX_BIT,
  output cped_err_type        ERR_FLAGS,
  output logic                ERR_IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cped_field_type field_q, field_d;
  logic           tx_q, tx_d;
  logic           txact_q, txact_d;
  logic           last_q, last_d;
  logic [2:0]     cnt_q, cnt_d;
  logic [14:0]    crc_q, crc_d;
  logic           crc_ok_q, crc_ok_d;
  logic           stuff_seen_q, stuff_seen_d;
  logic           take_q, take_d;
  logic           rxv_q, rxv_d;
  logic           rxb_q, rxb_d;
  cped_err_type   err_q, err_d, ev;

  function automatic logic [14:0] crc_step(input logic [14:0] c,
                                           input logic        b);
    crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? CRC_POLY : CRC_RST);
  endfunction

  // ----------------------------------------------------------------
  // Receive source and pin
  // ----------------------------------------------------------------
  // Digital loop keeps the pin recessive and silent on the bus
  wire loop_dig  = (LOOP_SEL == LOOP_DIGITAL);
  wire rx_line   = (LOOP_SEL == LOOP_PATTERN) ? PAT_RX :
                   loop_dig ? tx_q : CAN_RX;
  assign CAN_TX      = loop_dig ? RECESSIVE : tx_q;
  assign CAN_TX_OE_N = loop_dig;

  // ----------------------------------------------------------------
  // Decode of the sampled bit
  // ----------------------------------------------------------------
  wire tick       = CE & BIT_TICK;
  wire stuffed_f  = (field_q == FLD_STUFFED) | (field_q == FLD_CRC);
  wire crc_f      = (field_q == FLD_CRC);
  wire fixed_f    = (field_q == FLD_CRC_DELIM) |
                    (field_q == FLD_ACK_DELIM) | (field_q == FLD_EOF);
  wire is_stuff   = stuffed_f & (cnt_q == STUFF_RUN_3);
  wire stuff_bad  = is_stuff & (rx_line == last_q);
  wire data_bit   = stuffed_f & !is_stuff;
  wire run_next   = data_bit & (rx_line == last_q);
  wire [2:0] cnt_n = !stuffed_f ? CNT_RST :
                     run_next ? 3'(cnt_q + 3'h1) : 3'h1;
  wire stuff_due  = stuffed_f & (cnt_n == STUFF_RUN_3);
  wire crc_zero   = (crc_q == CRC_RST);

  // ----------------------------------------------------------------
  // Error events
  // ----------------------------------------------------------------
  always_comb begin
    ev.bit_err   = txact_q & BIT_CHK_EN & (field_q != FLD_IDLE) &
                   (field_q != FLD_ACK_SLOT) & (rx_line != tx_q);
    ev.crc_err   = !txact_q & (field_q == FLD_CRC_DELIM) &
                   !crc_zero;
    ev.ack_err   = txact_q & (field_q == FLD_ACK_SLOT) &
                   (rx_line == RECESSIVE);
    ev.form_err  = fixed_f & (rx_line == DOMINANT);
    ev.stuff_err = stuff_bad;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    field_d  = field_q;
    tx_d     = tx_q;
    txact_d  = txact_q;
    last_d   = last_q;
    cnt_d    = cnt_q;
    crc_d    = crc_q;
    crc_ok_d = crc_ok_q;
    stuff_seen_d = stuff_seen_q;
    take_d   = 1'b0;
    rxv_d    = 1'b0;
    rxb_d    = rxb_q;
    // Set wins over a clear arriving in the same cycle
    err_d    = (err_q & ~ERR_CLR) | (tick ? ev : '0);
    if (tick) begin
      cnt_d  = cnt_n;
      last_d = rx_line;
      if (stuff_bad) begin
        stuff_seen_d = 1'b1;
      end
      // Stale match from the last frame must not ack this one
      if (field_q == FLD_IDLE) begin
        crc_d        = CRC_RST;
        crc_ok_d     = 1'b0;
        stuff_seen_d = 1'b0;
      end else if (data_bit) begin
        // CRC bits run through the same divider: zero means match
        crc_d = crc_step(crc_q, rx_line);
        rxv_d = 1'b1;
        rxb_d = rx_line;
      end else if (!stuffed_f) begin
        rxv_d = 1'b1;
        rxb_d = rx_line;
      end
      if (field_q == FLD_CRC_DELIM) begin
        crc_ok_d = crc_zero & !stuff_seen_q;
      end
      if (stuff_due) begin
        // Receivers stay recessive on stuff bits
        tx_d = txact_q ? !rx_line : RECESSIVE;
      end else begin
        field_d = FIELD;
        txact_d = TX_ACTIVE;
        take_d  = 1'b1;
        unique case (FIELD)
          FLD_STUFFED:  tx_d = TX_ACTIVE ? TX_DATA : RECESSIVE;
          FLD_CRC:      tx_d = TX_ACTIVE ? crc_d[14]
                                         : RECESSIVE;
          FLD_ACK_SLOT: tx_d = (!TX_ACTIVE & crc_ok_d)
                               ? DOMINANT : RECESSIVE;
          default:      tx_d = RECESSIVE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      field_q  <= FLD_IDLE;
      tx_q     <= RECESSIVE;
      txact_q  <= 1'b0;
      last_q   <= RECESSIVE;
      cnt_q    <= CNT_RST;
      crc_q    <= CRC_RST;
      crc_ok_q <= 1'b0;
      stuff_seen_q <= 1'b0;
      take_q   <= 1'b0;
      rxv_q    <= 1'b0;
      rxb_q    <= RECESSIVE;
      err_q    <= '0;
    end else if (CE) begin
      field_q  <= field_d;
      tx_q     <= tx_d;
      txact_q  <= txact_d;
      last_q   <= last_d;
      cnt_q    <= cnt_d;
      crc_q    <= crc_d;
      crc_ok_q <= crc_ok_d;
      stuff_seen_q <= stuff_seen_d;
      take_q   <= take_d;
      rxv_q    <= rxv_d;
      rxb_q    <= rxb_d;
      err_q    <= err_d;
    end
  end

  assign TX_TAKE   = take_q;
  assign RX_VALID  = rxv_q;
  assign RX_BIT    = rxb_q;
  assign ERR_FLAGS = err_q;
  // CRC errors share the one interrupt with the other checks
  assign ERR_IRQ   = |(err_q & ERR_EN);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bit_err_set: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && txact_q && BIT_CHK_EN && field_q == FLD_STUFFED &&
    rx_line != tx_q |=> ERR_FLAGS.bit_err)
    else $error("bit error not flagged");

  a_bit_err_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(ERR_FLAGS.bit_err) |-> $past(BIT_CHK_EN))
    else $error("bit error flagged while check disabled");

  a_crc_err_set: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && !txact_q && field_q == FLD_CRC_DELIM && crc_q != CRC_RST
    |=> ERR_FLAGS.crc_err)
    else $error("crc mismatch not flagged");

  a_ack_err_set: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && txact_q && field_q == FLD_ACK_SLOT && rx_line
    |=> ERR_FLAGS.ack_err)
    else $error("missing ack not flagged");

  a_form_err_set: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && fixed_f && !rx_line |=> ERR_FLAGS.form_err)
    else $error("form violation not flagged");

  a_stuff_insert: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && txact_q && field_q == FLD_STUFFED && cnt_q == 3'h4 &&
    rx_line == last_q |=> tx_q == !$past(rx_line) && !TX_TAKE)
    else $error("stuff bit not inserted");

  a_stuff_err_set: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && stuffed_f && cnt_q == 3'h5 && rx_line == last_q
    |=> ERR_FLAGS.stuff_err)
    else $error("sixth equal bit not flagged");

  a_stuff_drop: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && stuffed_f && cnt_q == 3'h5 |=> !RX_VALID)
    else $error("stuff bit passed to receiver");

  a_flag_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    ERR_FLAGS.crc_err && !ERR_CLR.crc_err |=> ERR_FLAGS.crc_err)
    else $error("error flag dropped without clear");

  a_irq_crc: assert property (@(posedge CLK) disable iff (!RST_N)
    ERR_FLAGS.crc_err && ERR_EN.crc_err |-> ERR_IRQ)
    else $error("crc error did not raise interrupt");

  a_dig_loop: assert property (@(posedge CLK) disable iff (!RST_N)
    LOOP_SEL == LOOP_DIGITAL |-> CAN_TX_OE_N && rx_line == tx_q)
    else $error("digital loopback path wrong");

  a_ack_drive: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && !stuff_due && FIELD == FLD_ACK_SLOT && !TX_ACTIVE &&
    crc_ok_d |=> !tx_q)
    else $error("receiver did not acknowledge");

endmodule // cped_top

`default_nettype wire

// ==== hdl/cped_pkg.sv ====
// Shared types and constants for the CAN error detection block
package cped_pkg;

  // ----------------------------------------------------------------
  // Frame field of the bit on the bus
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    FLD_IDLE      = 7'h01,
    FLD_STUFFED   = 7'h02,
    FLD_CRC       = 7'h04,
    FLD_CRC_DELIM = 7'h08,
    FLD_ACK_SLOT  = 7'h10,
    FLD_ACK_DELIM = 7'h20,
    FLD_EOF       = 7'h40
  } cped_field_type;

  // ----------------------------------------------------------------
  // Receive source selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LOOP_NONE    = 2'h0,
    LOOP_PATTERN = 2'h1,
    LOOP_DIGITAL = 2'h2,
    LOOP_ANALOG  = 2'h3
  } cped_loop_type;

  // ----------------------------------------------------------------
  // Error flag carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bit_err;
    logic crc_err;
    logic ack_err;
    logic form_err;
    logic stuff_err;
  } cped_err_type;

  localparam int             STUFF_RUN   = 5;
  localparam logic [2:0]     STUFF_RUN_3 = 3'h5;
  localparam logic [14:0]    CRC_POLY    = 15'h4599;
  localparam logic [14:0]    CRC_RST     = 15'h0000;
  localparam logic [2:0]     CNT_RST     = 3'h0;
  localparam logic           RECESSIVE   = 1'b1;
  localparam logic           DOMINANT    = 1'b0;

endpackage

// ==== testbench/cped_node_model.sv ====
// Far-side CAN node on a shared wired-AND bus
`timescale 1ns/1ps
`default_nettype none

module cped_node_model
  import cped_pkg::*;
(
  input  wire logic tx,
  input  wire logic tx_oe_n,
  input  wire logic dom,
  output logic      rx
);
  // Pull-up holds the bus recessive when nobody drives it
  assign rx = (tx_oe_n | tx) & ~dom;
endmodule // cped_node_model

`default_nettype wire

// ==== testbench/cped_top_tb.sv ====
// Self-checking bench for the CAN error detection block
`timescale 1ns/1ps
`default_nettype none

module cped_top_tb
  import cped_pkg::*;
;
  logic           clk = 1'b0, rst_n = 1'b0, tick = 1'b0;
  logic           act = 1'b0, txd = 1'b1, chk = 1'b1;
  logic           pat = 1'b1, dom = 1'b0, ce = 1'b1;
  logic           rxp, ctx, oe_n, take, rv, rb, irq;
  cped_field_type fld = FLD_IDLE;
  cped_loop_type  lp = LOOP_NONE;
  cped_err_type   en = '1, clr = '0, flg;
  logic [14:0]    crc;
  int             err_total = 0, samples_checked = 0;

  cped_top i_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .BIT_TICK(tick),
    .TX_ACTIVE(act), .FIELD(fld), .TX_DATA(txd), .LOOP_SEL(lp),
    .BIT_CHK_EN(chk), .CAN_RX(rxp), .PAT_RX(pat), .ERR_EN(en),
    .ERR_CLR(clr), .CAN_TX(ctx), .CAN_TX_OE_N(oe_n), .TX_TAKE(take),
    .RX_VALID(rv), .RX_BIT(rb), .ERR_FLAGS(flg), .ERR_IRQ(irq));
  cped_node_model i_node (.tx(ctx), .tx_oe_n(oe_n), .dom(dom), .rx(rxp));

  always #12.5 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic ck(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t %s", $time, m);
    end
  endtask

  function automatic logic [14:0] nx(input logic [14:0] c, input logic b);
    nx = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? CRC_POLY : CRC_RST);
  endfunction

  // One bit time; p is the pattern bit that the next tick samples
  task automatic bt(input cped_field_type f, input logic d, input logic p);
    @(negedge clk);
    fld = f; txd = d; tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    pat = p;
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask

  task automatic clear_all;
    @(negedge clk);
    clr = '1;
    @(negedge clk);
    clr = '0;
    ck(|flg, 1'b0, "flags not cleared");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_tx(input logic ack);
    logic [11:0] v = 12'h03E;
    int i, run;
    logic last;
    act = 1'b1; lp = LOOP_NONE; crc = CRC_RST; run = 0; last = 1'b1;
    bt(FLD_IDLE, 1'b1, 1'b1);
    for (i = 0; i < 27 || run == 5; ) begin
      bt(i < 12 ? FLD_STUFFED : FLD_CRC, i < 12 ? v[11-i] : 1'b1, 1'b1);
      ck(take, run != 5, "stuff slot");
      if (run == 5) ck(ctx, ~last, "stuff bit");
      else if (i < 12) begin
        ck(ctx, v[11-i], "data bit");
        crc = nx(crc, v[11-i]);
        i++;
      end else begin
        ck(ctx, crc[26-i], "crc bit");
        i++;
      end
      run = (ctx === last) ? run + 1 : 1;
      last = ctx;
    end
    bt(FLD_CRC_DELIM, 1'b1, 1'b1);
    bt(FLD_ACK_SLOT, 1'b1, 1'b1);
    dom = ack;
    bt(FLD_ACK_DELIM, 1'b1, 1'b1);
    dom = 1'b0;
    repeat (7) bt(FLD_EOF, 1'b1, 1'b1);
    bt(FLD_IDLE, 1'b1, 1'b1);
    ck(flg.ack_err, ~ack, "ack flag");
    ck(irq, ~ack, "ack irq");
    ck(flg.bit_err, 1'b0, "false bit error");
    clear_all;
  endtask

  // m: 0 good, 1 bad crc, 2 missing stuff bit, 3 dominant delimiter
  task automatic t_rx(input int m);
    logic [11:0] v = 12'h03E;
    int i, run;
    logic last, b;
    act = 1'b0; lp = LOOP_PATTERN; crc = CRC_RST; run = 0; last = 1'b1;
    bt(FLD_IDLE, 1'b1, 1'b1);
    while (i < 27 || (run == 5 && m != 2)) begin
      if (run == 5 && m != 2) b = ~last;
      else begin
        b = i < 12 ? v[11-i] : crc[26-i] ^ (m == 1 && i == 20);
        if (i < 12) crc = nx(crc, b);
        i++;
      end
      bt(i <= 12 ? FLD_STUFFED : FLD_CRC, 1'b1, b);
      run = (b == last) ? run + 1 : 1;
      last = b;
    end
    bt(FLD_CRC_DELIM, 1'b1, m != 3);
    bt(FLD_ACK_SLOT, 1'b1, 1'b1);
    ck(ctx, !(m == 0 || m == 3), "ack drive");
    bt(FLD_ACK_DELIM, 1'b1, 1'b1);
    repeat (7) bt(FLD_EOF, 1'b1, 1'b1);
    bt(FLD_IDLE, 1'b1, 1'b1);
    if (m != 2) ck(flg.crc_err, m == 1, "crc flag");
    ck(flg.stuff_err, m == 2, "stuff flag");
    if (m != 2) ck(flg.form_err, m == 3, "form flag");
    ck(irq, m != 0, "error irq");
    clear_all;
  endtask

  task automatic t_loop;
    act = 1'b1; dom = 1'b1; chk = 1'b0; lp = LOOP_DIGITAL;
    bt(FLD_STUFFED, 1'b1, 1'b1);
    bt(FLD_STUFFED, 1'b1, 1'b1);
    ck(oe_n & ctx, 1'b1, "digital loop pin");
    ck(rv & rb, 1'b1, "digital loop rx");
    lp = LOOP_NONE;
    bt(FLD_STUFFED, 1'b1, 1'b1);
    ck(rb | flg.bit_err, 1'b0, "check disabled");
    chk = 1'b1;
    bt(FLD_STUFFED, 1'b1, 1'b1);
    ck(flg.bit_err & irq, 1'b1, "bit error");
    ce = 1'b0;
    clr = '1;
    bt(FLD_STUFFED, 1'b1, 1'b1);
    ck(flg.bit_err, 1'b1, "frozen by enable");
    ce = 1'b1;
    clr = '0;
    lp = LOOP_ANALOG;
    @(negedge clk);
    ck(oe_n, 1'b0, "analog loop drive");
    bt(FLD_STUFFED, 1'b1, 1'b1);
    ck(rb, 1'b0, "analog loop rx from pin");
    dom = 1'b0;
    do_reset;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error %0t timeout", $time);
    wrap_up;
  end

  initial begin
    do_reset;
    t_tx(1'b1);
    $display("test tx acked ended");
    t_tx(1'b0);
    $display("test tx unacked ended");
    for (int m = 0; m < 4; m++) begin
      do_reset;
      t_rx(m);
      $display("test rx mode %0d ended", m);
    end
    t_loop;
    $display("test loopback ended");
    wrap_up;
  end
endmodule // cped_top_tb

`default_nettype wire
